// ### logic/acc_load_transfer_ops.v
// Accumulator transfer instruction group with an AHB-Lite register slave.
//
// Operation
// - RAM load op puts the nibble at the data pointer into the accumulator.
// - Same op then sets column register to its old value XOR immediate.
// - Clock register read op copies the clock control register to accumulator.
// - Opcode 10'h257 is decoded and copies pull-up control zero to accumulator.
// - Its own read op copies pull-up control one to the accumulator.
// - Opcode 10'h244 is decoded and moves A/D control one to the accumulator.
// - Its own read op moves A/D control two to the accumulator.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "acc_transfer_regs.vh"

module acc_load_transfer_ops (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Instruction issue from the fetch sequencer.
  input  wire        instr_valid,
  input  wire [9:0]  instr_code,
  // Core state outputs.
  output reg  [3:0]  acc_q,
  output reg  [3:0]  column_x_q,
  output reg         carry_q,
  output reg         skip_next_q,
  output reg         exec_done_q,
  // Peripheral control register outputs.
  output reg  [3:0]  clock_control_reg_q,
  output reg  [3:0]  pullup_control_zero_q,
  output reg  [3:0]  pullup_control_one_q,
  output reg  [3:0]  adc_control_one_q,
  output reg  [3:0]  adc_control_two_q,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam [3:0] S_IDLE    = 4'h1;
  localparam [3:0] S_WRITE   = 4'h2;
  localparam [3:0] S_RD_WAIT = 4'h4;
  localparam [3:0] S_READ    = 4'h8;

  reg  [3:0]           state_q;
  reg  [3:0]           state_d;
  reg  [7:0]           addr_q;
  reg                  addr_hit_q;
  reg  [3:0]           row_y_q;
  reg  [7:0]           ram_addr_q;
  reg  [7:0]           count_q;
  reg  [`OP_COUNT-1:0] last_op_q;
  reg  [31:0]          rd_mux;
  reg  [3:0]           acc_d;
  reg  [3:0]           column_x_d;

  wire [`OP_COUNT-1:0] op_sel;
  wire [3:0]           imm_field;
  wire [3:0]           ram_dp_data;
  wire [3:0]           ram_sw_data;
  wire                 exec_any;
  wire                 addr_phase;
  wire                 wr_commit;
  wire                 wr_hit;
  wire                 wr_acc;
  wire                 wr_column;
  wire                 wr_row;
  wire                 wr_carry;
  wire                 wr_clock_ctrl;
  wire                 wr_pullup_zero;
  wire                 wr_pullup_one;
  wire                 wr_adc_one;
  wire                 wr_adc_two;
  wire                 wr_ram_addr;
  wire                 wr_ram_data;
  wire                 wr_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode and data memory.

  op_decoder u_decoder (
    .instr_code (instr_code),
    .op_sel     (op_sel),
    .imm_field  (imm_field)
  );

  data_ram u_ram (
    .clk       (clk),
    .wr_en     (wr_ram_data),
    .wr_addr   (ram_addr_q),
    .wr_data   (hwdata[3:0]),
    .rd_addr_a ({column_x_q, row_y_q}),
    .rd_data_a (ram_dp_data),
    .rd_addr_b (ram_addr_q),
    .rd_data_b (ram_sw_data)
  );

  // An instruction of the group executes in the cycle it is offered.
  assign exec_any = instr_valid && (|op_sel);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking.

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_commit  = (state_q == S_WRITE) && hready;

  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE, S_WRITE, S_READ: begin
        if (addr_phase && hwrite) begin
          state_d = S_WRITE;
        end else if (addr_phase) begin
          state_d = S_RD_WAIT;
        end else begin
          state_d = S_IDLE;
        end
      end
      S_RD_WAIT: begin
        state_d = S_READ;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= S_IDLE;
      addr_q     <= 8'h00;
      addr_hit_q <= 1'b0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      state_q <= state_d;
      hresp   <= 1'b0;
      if (addr_phase) begin
        addr_q     <= haddr[7:0];
        addr_hit_q <= (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
      end
      // A read takes one wait state so that its data come from a flip-flop.
      hreadyout <= (state_d != S_RD_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register write strobes.

  assign wr_hit         = wr_commit && addr_hit_q;
  assign wr_acc         = wr_hit && (addr_q == `OFS_ACC);
  assign wr_column      = wr_hit && (addr_q == `OFS_COLUMN_X);
  assign wr_row         = wr_hit && (addr_q == `OFS_ROW_Y);
  assign wr_carry       = wr_hit && (addr_q == `OFS_CARRY);
  assign wr_clock_ctrl  = wr_hit && (addr_q == `OFS_CLOCK_CTRL);
  assign wr_pullup_zero = wr_hit && (addr_q == `OFS_PULLUP_ZERO);
  assign wr_pullup_one  = wr_hit && (addr_q == `OFS_PULLUP_ONE);
  assign wr_adc_one     = wr_hit && (addr_q == `OFS_ADC_ONE);
  assign wr_adc_two     = wr_hit && (addr_q == `OFS_ADC_TWO);
  assign wr_ram_addr    = wr_hit && (addr_q == `OFS_RAM_ADDR);
  assign wr_ram_data    = wr_hit && (addr_q == `OFS_RAM_DATA);
  assign wr_status      = wr_hit && (addr_q == `OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data multiplexer.

  always @* begin
    rd_mux = `RST_WORD;
    if (addr_hit_q) begin
      case (addr_q)
        `OFS_ACC:         rd_mux = {28'h0000000, acc_q};
        `OFS_COLUMN_X:    rd_mux = {28'h0000000, column_x_q};
        `OFS_ROW_Y:       rd_mux = {28'h0000000, row_y_q};
        `OFS_CARRY:       rd_mux = {31'h00000000, carry_q};
        `OFS_CLOCK_CTRL:  rd_mux = {28'h0000000, clock_control_reg_q};
        `OFS_PULLUP_ZERO: rd_mux = {28'h0000000, pullup_control_zero_q};
        `OFS_PULLUP_ONE:  rd_mux = {28'h0000000, pullup_control_one_q};
        `OFS_ADC_ONE:     rd_mux = {28'h0000000, adc_control_one_q};
        `OFS_ADC_TWO:     rd_mux = {28'h0000000, adc_control_two_q};
        `OFS_RAM_ADDR:    rd_mux = {24'h000000, ram_addr_q};
        `OFS_RAM_DATA:    rd_mux = {28'h0000000, ram_sw_data};
        `OFS_STATUS:      rd_mux = {18'h00000, last_op_q, count_q};
        default:          rd_mux = `RST_WORD;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= `RST_WORD;
    end else if (state_q == S_RD_WAIT) begin
      hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Accumulator and column register next values.

  always @* begin
    acc_d      = acc_q;
    column_x_d = column_x_q;
    if (wr_acc) begin
      acc_d = hwdata[3:0];
    end
    if (wr_column) begin
      column_x_d = hwdata[3:0];
    end
    // An executing instruction has priority over a software write.
    if (instr_valid) begin
      if (op_sel[`OP_LOAD_RAM]) begin
        acc_d      = ram_dp_data;
        column_x_d = column_x_q ^ imm_field;
      end else if (op_sel[`OP_CLOCK_CTRL]) begin
        acc_d = clock_control_reg_q;
      end else if (op_sel[`OP_PULLUP_ZERO]) begin
        acc_d = pullup_control_zero_q;
      end else if (op_sel[`OP_PULLUP_ONE]) begin
        acc_d = pullup_control_one_q;
      end else if (op_sel[`OP_ADC_ONE]) begin
        acc_d = adc_control_one_q;
      end else if (op_sel[`OP_ADC_TWO]) begin
        acc_d = adc_control_two_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core state registers.

  always @(posedge clk) begin
    if (!rst_n) begin
      acc_q       <= `RST_NIBBLE;
      column_x_q  <= `RST_NIBBLE;
      row_y_q     <= `RST_NIBBLE;
      carry_q     <= 1'b0;
      skip_next_q <= 1'b0;
      exec_done_q <= 1'b0;
      count_q     <= `RST_COUNT;
      last_op_q   <= {`OP_COUNT{1'b0}};
    end else begin
      acc_q       <= acc_d;
      column_x_q  <= column_x_d;
      // The group never requests a skip of the next instruction.
      skip_next_q <= 1'b0;
      exec_done_q <= exec_any;
      if (exec_any) begin
        count_q   <= count_q + 8'h01;
        last_op_q <= op_sel;
      end
      if (wr_row) begin
        row_y_q <= hwdata[3:0];
      end
      // Carry is touched only by software, never by this group.
      if (wr_carry) begin
        carry_q <= hwdata[0];
      end
      // A status write clears the count even when an op executes in the same cycle.
      if (wr_status) begin
        count_q <= `RST_COUNT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral control registers and the memory window pointer.

  always @(posedge clk) begin
    if (!rst_n) begin
      clock_control_reg_q   <= `RST_NIBBLE;
      pullup_control_zero_q <= `RST_NIBBLE;
      pullup_control_one_q  <= `RST_NIBBLE;
      adc_control_one_q     <= `RST_NIBBLE;
      adc_control_two_q     <= `RST_NIBBLE;
      ram_addr_q            <= `RST_RAM_ADDR;
    end else begin
      if (wr_clock_ctrl) begin
        clock_control_reg_q <= hwdata[3:0];
      end
      if (wr_pullup_zero) begin
        pullup_control_zero_q <= hwdata[3:0];
      end
      if (wr_pullup_one) begin
        pullup_control_one_q <= hwdata[3:0];
      end
      if (wr_adc_one) begin
        adc_control_one_q <= hwdata[3:0];
      end
      if (wr_adc_two) begin
        adc_control_two_q <= hwdata[3:0];
      end
      if (wr_ram_addr) begin
        ram_addr_q <= hwdata[7:0];
      end
    end
  end

endmodule // acc_load_transfer_ops

// ### logic/acc_transfer_regs.vh
// Constants for the accumulator transfer block: offsets, opcodes, reset values.
`ifndef ACC_TRANSFER_REGS_VH
`define ACC_TRANSFER_REGS_VH

// Register word offsets on the AHB-Lite bus (byte addresses).
`define OFS_ACC          8'h00
`define OFS_COLUMN_X     8'h04
`define OFS_ROW_Y        8'h08
`define OFS_CARRY        8'h0C
`define OFS_CLOCK_CTRL   8'h10
`define OFS_PULLUP_ZERO  8'h14
`define OFS_PULLUP_ONE   8'h18
`define OFS_ADC_ONE      8'h1C
`define OFS_ADC_TWO      8'h20
`define OFS_RAM_ADDR     8'h24
`define OFS_RAM_DATA     8'h28
`define OFS_STATUS       8'h2C

// Status register field positions.
`define STATUS_COUNT_LSB 0
`define STATUS_COUNT_MSB 7
`define STATUS_LAST_LSB  8
`define STATUS_LAST_MSB  13

// Opcode patterns and masks, ten bits each.
`define OPC_LOAD_RAM     10'h2C0
`define MSK_LOAD_RAM     10'h3F0
`define OPC_CLOCK_CTRL   10'h252
`define OPC_PULLUP_ZERO  10'h257
`define OPC_PULLUP_ONE   10'h25E
`define OPC_ADC_ONE      10'h244
`define OPC_ADC_TWO      10'h245
`define MSK_FULL         10'h3FF

// Operation select indices.
`define OP_LOAD_RAM      0
`define OP_CLOCK_CTRL    1
`define OP_PULLUP_ZERO   2
`define OP_PULLUP_ONE    3
`define OP_ADC_ONE       4
`define OP_ADC_TWO       5
`define OP_COUNT         6

// Reset values.
`define RST_NIBBLE       4'h0
`define RST_RAM_ADDR     8'h00
`define RST_COUNT        8'h00
`define RST_WORD         32'h00000000

// Transfer timing in instruction cycles.
`define EXEC_CYCLES      1

`endif

// ### logic/data_ram.v
// Nibble-wide data memory with one write port and two read ports.
`timescale 1ns/1ps

module data_ram (
  // Clock.
  input  wire       clk,
  // Write port.
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [3:0] wr_data,
  // Read ports.
  input  wire [7:0] rd_addr_a,
  output wire [3:0] rd_data_a,
  input  wire [7:0] rd_addr_b,
  output wire [3:0] rd_data_b
);

  reg [3:0] mem [0:255];

  // Memory is written on the clock edge.
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

endmodule // data_ram

// ### logic/op_decoder.v
// Combinational decoder for the accumulator transfer instruction group.
`timescale 1ns/1ps
`include "acc_transfer_regs.vh"

module op_decoder (
  // Instruction word.
  input  wire [9:0]               instr_code,
  // Decoded operation and immediate.
  output wire [`OP_COUNT-1:0]     op_sel,
  output wire [3:0]               imm_field
);

  localparam [10*`OP_COUNT-1:0] OPC_TABLE = {`OPC_ADC_TWO, `OPC_ADC_ONE, `OPC_PULLUP_ONE,
                                             `OPC_PULLUP_ZERO, `OPC_CLOCK_CTRL, `OPC_LOAD_RAM};
  localparam [10*`OP_COUNT-1:0] MSK_TABLE = {`MSK_FULL, `MSK_FULL, `MSK_FULL,
                                             `MSK_FULL, `MSK_FULL, `MSK_LOAD_RAM};

  // Each entry matches its opcode under its mask.
  genvar i;
  generate
    for (i = 0; i < `OP_COUNT; i = i + 1) begin : g_match
      assign op_sel[i] = ((instr_code & MSK_TABLE[10*i +: 10]) == OPC_TABLE[10*i +: 10]);
    end
  endgenerate

  assign imm_field = instr_code[3:0];

endmodule // op_decoder

// ### tb/acc_load_transfer_ops_tb.sv
// Self-checking testbench for the accumulator transfer block.
`timescale 1ns/1ps
`include "acc_transfer_regs.vh"
module acc_load_transfer_ops_tb;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [3:0]  xe;
  logic [9:0]  ops [5] = '{10'h252, 10'h257, 10'h25E, 10'h244, 10'h245};
  logic [3:0]  vals [5] = '{4'h3, 4'h5, 4'hA, 4'hC, 4'h6};
  wire         instr_valid, hready, carry_q, skip_next_q, exec_done_q, hresp;
  wire  [9:0]  instr_code;
  wire  [3:0]  acc_q, column_x_q, ck_r, pu0_r, pu1_r, ad1_r, ad2_r;
  wire  [31:0] hrdata;
  int          fails = 0;
  int          total_checks = 0;

  always #2.5 clk = ~clk;

  acc_load_transfer_ops u_acc_load_transfer_ops (.clk, .rst_n, .instr_valid, .instr_code,
    .acc_q, .column_x_q, .carry_q, .skip_next_q, .exec_done_q,
    .clock_control_reg_q(ck_r), .pullup_control_zero_q(pu0_r), .pullup_control_one_q(pu1_r),
    .adc_control_one_q(ad1_r), .adc_control_two_q(ad2_r), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp);
  fetch_model u_fetch_model (.clk, .instr_valid, .instr_code);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge clk);
    while (!hready) @(posedge clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, `OFS_CARRY, 32'h1);
    for (int i = 0; i < 5; i++) bus(1'h1, 8'h10 + 8'(4 * i), {28'h0, vals[i]});
    for (int i = 0; i < 6; i++) begin
      u_fetch_model.issue((i < 5) ? ops[i] : 10'h3FF);
      if (i > 0) chk(acc_q, vals[i - 1]);
      if (i > 0) chk(exec_done_q, 32'h1);
    end
    u_fetch_model.idle();
    @(posedge clk);
    chk(acc_q, vals[4]);
    chk(exec_done_q, 32'h0);
    chk({ad2_r, ad1_r, pu1_r, pu0_r, ck_r}, {vals[4], vals[3], vals[2], vals[1], vals[0]});
    for (int x = 0; x < 16; x++) begin
      bus(1'h1, `OFS_RAM_ADDR, {24'h0, 4'(x), 4'h9});
      bus(1'h1, `OFS_RAM_DATA, {28'h0, ~4'(x)});
    end
    bus(1'h1, `OFS_ROW_Y, 32'h9);
    bus(1'h1, `OFS_COLUMN_X, 32'h3);
    xe = 4'h3;
    for (int j = 0; j < 17; j++) begin
      if (j < 16) u_fetch_model.issue(10'h2C0 | 10'(j));
      else u_fetch_model.idle();
      if (j == 16) @(posedge clk);
      if (j > 0) begin
        chk(acc_q, {28'h0, ~xe});
        xe = xe ^ 4'(j - 1);
        chk(column_x_q, {28'h0, xe});
        chk(skip_next_q, 32'h0);
      end
    end
    chk(carry_q, 32'h1);
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h115);
    bus(1'h1, `OFS_STATUS, 32'h0);
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h100);
    bus(1'h0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule // acc_load_transfer_ops_tb

// ### tb/acc_ops_chk.sv
// Assertion checker for the accumulator transfer block.
`timescale 1ns/1ps
module acc_ops_chk (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst_n,
  // Instruction port and core state.
  input wire logic       instr_valid,
  input wire logic [9:0] instr_code,
  input wire logic [3:0] acc_q,
  input wire logic [3:0] column_x_q,
  input wire logic       skip_next_q,
  input wire logic       exec_done_q,
  // Control registers.
  input wire logic [3:0] clock_control_reg_q,
  input wire logic [3:0] pullup_control_zero_q,
  input wire logic [3:0] pullup_control_one_q,
  input wire logic [3:0] adc_control_one_q,
  input wire logic [3:0] adc_control_two_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic ld = instr_valid && instr_code[9:4] == 6'h2C;
  wire logic grp = ld || instr_valid &&
    instr_code inside {10'h252, 10'h257, 10'h25E, 10'h244, 10'h245};
  property rd_p(logic [9:0] c, logic [3:0] r);
    instr_valid && instr_code == c |=> acc_q == $past(r);
  endproperty
  a_column_xor:
    assert property (ld |=> column_x_q == ($past(column_x_q) ^ $past(instr_code[3:0])))
    else $error("column register not toggled by immediate");
  a_clock_read:
    assert property (rd_p(10'h252, clock_control_reg_q)) else $error("clock read wrong");
  a_pullup_zero:
    assert property (rd_p(10'h257, pullup_control_zero_q)) else $error("pull-up 0 read wrong");
  a_pullup_one:
    assert property (rd_p(10'h25E, pullup_control_one_q)) else $error("pull-up 1 read wrong");
  a_adc_one:
    assert property (rd_p(10'h244, adc_control_one_q)) else $error("adc 1 read wrong");
  a_adc_two:
    assert property (rd_p(10'h245, adc_control_two_q)) else $error("adc 2 read wrong");
  a_done_pulse:
    assert property (grp |=> exec_done_q) else $error("no done pulse");
  a_done_only:
    assert property (!grp |=> !exec_done_q) else $error("stray done pulse");
  a_never_skip:
    assert property (!skip_next_q) else $error("skip raised");
  c_load: cover property (ld ##1 ld);
  c_clock: cover property (instr_valid && instr_code == 10'h252);
  c_done_run: cover property (exec_done_q [*5]);
endmodule // acc_ops_chk

bind acc_load_transfer_ops acc_ops_chk u_acc_ops_chk (.clk, .rst_n, .instr_valid,
  .instr_code, .acc_q, .column_x_q, .skip_next_q, .exec_done_q, .clock_control_reg_q,
  .pullup_control_zero_q, .pullup_control_one_q, .adc_control_one_q, .adc_control_two_q);

// ### tb/fetch_model.sv
// Model of the fetch sequencer that offers one instruction word per cycle.
`timescale 1ns/1ps
module fetch_model (
  // Clock.
  input  wire logic       clk,
  // Instruction issue.
  output      logic       instr_valid,
  output      logic [9:0] instr_code
);
  initial begin
    instr_valid = 1'h0;
    instr_code  = 10'h3FF;
  end
  // Offers one word and returns at the edge that takes it.
  task automatic issue(input logic [9:0] c);
    instr_valid <= 1'h1;
    instr_code  <= c;
    @(posedge clk);
  endtask
  // Withdraws the offer; the code lines stop showing the last word.
  task automatic idle;
    instr_valid <= 1'h0;
    instr_code  <= ~instr_code;
  endtask
endmodule // fetch_model
